// ---- inc/wdtc_pkg.sv ----
// watchdog timer package: register map, config word layout, timing counts
// assumes a single 200 MHz core clock and a plain strobe register port
package wdtc_pkg;

   // core clock and low-power rc oscillator rates
   localparam int unsigned CORE_CLK_HZ       = 200_000_000;
   localparam int unsigned LOW_POWER_RC_OSC_HZ           = 32_000;
   localparam int unsigned LOW_POWER_RC_OSC_DIV          = CORE_CLK_HZ / LOW_POWER_RC_OSC_HZ;

   // prescaler periods in microseconds and the oscillator ticks they take
   localparam int unsigned PRE_PERIOD_SHORT_US = 1000;
   localparam int unsigned PRE_PERIOD_LONG_US  = 4000;
   localparam int unsigned PRE_TICKS_SHORT   = PRE_PERIOD_SHORT_US * LOW_POWER_RC_OSC_HZ / 1_000_000;
   localparam int unsigned PRE_TICKS_LONG    = PRE_PERIOD_LONG_US * LOW_POWER_RC_OSC_HZ / 1_000_000;
   localparam int unsigned PRE_W             = 7;
   localparam int unsigned POST_W            = 16;
   localparam int unsigned POST_SEL_W        = 4;

   // register port
   localparam int unsigned ADDR_W            = 8;
   localparam int unsigned DATA_W            = 32;
   localparam logic [7:0]  OFS_CONFIG        = 8'h00;
   localparam logic [7:0]  OFS_RESET_CTRL    = 8'h04;
   localparam logic [7:0]  OFS_IRQ_STATUS    = 8'h08;
   localparam logic [7:0]  OFS_IRQ_CLEAR     = 8'h0C;
   localparam logic [7:0]  OFS_IRQ_ENABLE    = 8'h10;
   localparam logic [7:0]  OFS_COUNT         = 8'h14;

   // configuration word layout
   localparam int unsigned CFG_W             = 24;
   localparam int unsigned CFG_POST_LSB      = 0;
   localparam int unsigned CFG_PRESEL_BIT    = 4;
   localparam int unsigned CFG_WINDOW_MODE_DISABLE_BIT    = 6;
   localparam int unsigned CFG_EN_BIT        = 7;
   localparam logic [23:0] CFG_IMPL_MASK     = 24'h00_00DF;
   localparam logic [23:0] CFG_UNPROG        = 24'hFF_FFFF;

   // reset control register bits
   localparam int unsigned RC_IDLE_BIT       = 2;
   localparam int unsigned RC_SLEEP_BIT      = 3;
   localparam int unsigned RC_TIMEOUT_BIT    = 4;
   localparam int unsigned RC_SOFT_EN_BIT    = 5;

   // interrupt status bits
   localparam int unsigned IRQ_W             = 2;
   localparam int unsigned IRQ_TIMEOUT_BIT   = 0;
   localparam int unsigned IRQ_WAKE_BIT      = 1;

   // power state, gray along run -> sleep -> idle
   typedef enum logic [1:0] {
      WDTC_RUN   = 2'b00,
      WDTC_SLEEP = 2'b01,
      WDTC_IDLE  = 2'b11
   } wdtc_pstate_t;

endpackage

// ---- design/wdtc_watchdog.sv ----
// watchdog timer: low_power_rc_osc tick divider, prescaler, postscaler, config word, reset control
// assumes all event inputs are one-cycle pulses from logic on core_clk
`timescale 1ns/10ps
module wdtc_watchdog
   import wdtc_pkg::*;
#(
   parameter int unsigned LOW_POWER_RC_OSC_DIV_P = LOW_POWER_RC_OSC_DIV
) (
   // clock and reset
   input  wire logic                clk_core_placeholder_unused_never,
   input  wire logic                core_clk,
   input  wire logic                rst_b,
   // register port
   input  wire logic [ADDR_W-1:0]   reg_addr,
   input  wire logic [DATA_W-1:0]   reg_wdata,
   input  wire logic                reg_wr,
   input  wire logic                reg_rd,
   output logic      [DATA_W-1:0]   reg_rdata,
   // core events
   input  wire logic                dev_reset_in,
   input  wire logic                clk_switch_done,
   input  wire logic                power_save_instr,
   input  wire logic                power_save_idle,
   input  wire logic                clear_watchdog_instr,
   input  wire logic                wake_in,
   // outputs
   output logic                     low_power_rc_osc_en,
   output logic                     wdt_reset_out,
   output logic                     wake_out,
   output logic                     sleep_active,
   output logic                     idle_active,
   output logic                     window_mode_active,
   output logic                     irq
);

   logic [CFG_W-1:0]    cfg_reg;
   logic                cfg_prog_reg;
   logic [DATA_W-1:0]   rdata_reg;
   logic                soft_en_reg;
   logic                timeout_flag_reg;
   logic                sleep_bit_reg;
   logic                idle_bit_reg;
   logic [IRQ_W-1:0]    irq_stat_reg;
   logic [IRQ_W-1:0]    irq_en_reg;
   logic                irq_reg;
   logic [12:0]         low_power_rc_osc_cnt_reg;
   logic [PRE_W-1:0]    pre_cnt_reg;
   logic [POST_W-1:0]   post_cnt_reg;
   logic                low_power_rc_osc_en_reg;
   logic                wdt_reset_reg;
   logic                wake_reg;
   logic                window_reg;
   logic                slp_reg;
   logic                idl_reg;
   wdtc_pstate_t        pstate_reg;
   wdtc_pstate_t        pstate_next;

   // a shorter divider for simulation must still fit the counter
   localparam logic [12:0] LOW_POWER_RC_OSC_LAST = 13'(LOW_POWER_RC_OSC_DIV_P - 1);

   function automatic logic [PRE_W-1:0] pre_last(input logic long_sel);
      pre_last = long_sel ? PRE_W'(PRE_TICKS_LONG - 1) : PRE_W'(PRE_TICKS_SHORT - 1);
   endfunction

   function automatic logic [POST_W-1:0] post_last(input logic [POST_SEL_W-1:0] sel);
      post_last = (POST_W'(1) << sel) - POST_W'(1);
   endfunction

   function automatic logic wr_hit(input logic [ADDR_W-1:0] ofs);
      wr_hit = reg_wr && (reg_addr == ofs);
   endfunction

   logic                    cfg_en;
   logic                    cfg_presel;
   logic                    cfg_window_mode_disable;
   logic [POST_SEL_W-1:0]   cfg_post;
   logic                    wdt_en;
   logic                    dev_any_reset;
   logic                    lp_entry;
   logic                    lp_exit;
   logic                    in_lp;
   logic                    cnt_clear;
   logic                    low_power_rc_osc_tick;
   logic                    pre_tick;
   logic                    timeout_hit;
   logic                    rc_write;

   assign cfg_en        = cfg_reg[CFG_EN_BIT];
   assign cfg_presel    = cfg_reg[CFG_PRESEL_BIT];
   assign cfg_window_mode_disable    = cfg_reg[CFG_WINDOW_MODE_DISABLE_BIT];
   assign cfg_post      = cfg_reg[CFG_POST_LSB +: POST_SEL_W];
   assign wdt_en        = cfg_en | soft_en_reg;
   assign dev_any_reset = dev_reset_in | wdt_reset_reg;
   assign in_lp         = (pstate_reg != WDTC_RUN);
   assign lp_entry      = power_save_instr && !in_lp;
   assign lp_exit       = in_lp && (wake_in || timeout_hit);
   assign rc_write      = wr_hit(OFS_RESET_CTRL);

   // every documented clearing event zeroes the whole chain
   assign cnt_clear = dev_any_reset
                    | clk_switch_done
                    | lp_entry
                    | (in_lp && wake_in)
                    | (clear_watchdog_instr && !in_lp)
                    | !wdt_en;

   assign low_power_rc_osc_tick   = wdt_en && (low_power_rc_osc_cnt_reg == LOW_POWER_RC_OSC_LAST);
   assign pre_tick    = low_power_rc_osc_tick && (pre_cnt_reg == pre_last(cfg_presel));
   // a clearing event in the same cycle wins over the expiry; counting goes on in sleep/idle
   assign timeout_hit = pre_tick && (post_cnt_reg == post_last(cfg_post)) && !cnt_clear;

   // oscillator tick divider
   always_ff @(posedge core_clk) begin
      if (!rst_b || cnt_clear || low_power_rc_osc_tick) begin
         low_power_rc_osc_cnt_reg <= 13'h0000;
      end else begin
         low_power_rc_osc_cnt_reg <= low_power_rc_osc_cnt_reg + 13'h0001;
      end
   end

   // prescaler and postscaler
   always_ff @(posedge core_clk) begin
      if (!rst_b || cnt_clear || timeout_hit) begin
         pre_cnt_reg  <= '0;
         post_cnt_reg <= '0;
      end else if (pre_tick) begin
         pre_cnt_reg  <= '0;
         post_cnt_reg <= post_cnt_reg + POST_W'(1);
      end else if (low_power_rc_osc_tick) begin
         pre_cnt_reg  <= pre_cnt_reg + PRE_W'(1);
      end
   end

   // power state
   always_comb begin
      pstate_next = pstate_reg;
      case (pstate_reg)
         WDTC_RUN: begin
            if (dev_reset_in) begin
               pstate_next = WDTC_RUN;
            end else if (power_save_instr) begin
               pstate_next = power_save_idle ? WDTC_IDLE : WDTC_SLEEP;
            end
         end
         WDTC_SLEEP, WDTC_IDLE: begin
            if (dev_reset_in || lp_exit) begin
               pstate_next = WDTC_RUN;
            end
         end
         default: pstate_next = WDTC_RUN;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         pstate_reg <= WDTC_RUN;
         slp_reg    <= 1'b0;
         idl_reg    <= 1'b0;
      end else begin
         pstate_reg <= pstate_next;
         slp_reg    <= (pstate_next == WDTC_SLEEP);
         idl_reg    <= (pstate_next == WDTC_IDLE);
      end
   end

   // timeout outcomes: reset in run, wake in sleep/idle
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         wdt_reset_reg <= 1'b0;
         wake_reg      <= 1'b0;
      end else begin
         wdt_reset_reg <= timeout_hit && !in_lp;
         wake_reg      <= lp_exit;
      end
   end

   // configuration word, programmed once after power-on
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         cfg_reg      <= CFG_UNPROG;
         cfg_prog_reg <= 1'b0;
      end else if (wr_hit(OFS_CONFIG) && !cfg_prog_reg) begin
         cfg_reg      <= reg_wdata[CFG_W-1:0] | ~CFG_IMPL_MASK;
         cfg_prog_reg <= 1'b1;
      end
   end

   // software enable
   always_ff @(posedge core_clk) begin
      if (!rst_b || dev_any_reset) begin
         soft_en_reg <= 1'b0;
      end else if (rc_write) begin
         soft_en_reg <= reg_wdata[RC_SOFT_EN_BIT];
      end
   end

   // sticky flags: hardware set wins, software writes zero to clear
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         timeout_flag_reg <= 1'b0;
         sleep_bit_reg    <= 1'b0;
         idle_bit_reg     <= 1'b0;
      end else begin
         timeout_flag_reg <= timeout_hit
                           | (timeout_flag_reg && !(rc_write && !reg_wdata[RC_TIMEOUT_BIT]));
         sleep_bit_reg    <= (lp_entry && !power_save_idle)
                           | (sleep_bit_reg && !(rc_write && !reg_wdata[RC_SLEEP_BIT]));
         idle_bit_reg     <= (lp_entry && power_save_idle)
                           | (idle_bit_reg && !(rc_write && !reg_wdata[RC_IDLE_BIT]));
      end
   end

   // interrupt status, enable and output
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         irq_stat_reg <= '0;
         irq_en_reg   <= '0;
         irq_reg      <= 1'b0;
      end else begin
         irq_stat_reg[IRQ_TIMEOUT_BIT] <= timeout_hit
            | (irq_stat_reg[IRQ_TIMEOUT_BIT] && !(wr_hit(OFS_IRQ_CLEAR) && reg_wdata[IRQ_TIMEOUT_BIT]));
         irq_stat_reg[IRQ_WAKE_BIT]    <= lp_exit
            | (irq_stat_reg[IRQ_WAKE_BIT] && !(wr_hit(OFS_IRQ_CLEAR) && reg_wdata[IRQ_WAKE_BIT]));
         if (wr_hit(OFS_IRQ_ENABLE)) begin
            irq_en_reg <= reg_wdata[IRQ_W-1:0];
         end
         irq_reg <= |(irq_stat_reg & irq_en_reg);
      end
   end

   // oscillator enable and window mode outputs
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         low_power_rc_osc_en_reg <= 1'b0;
         window_reg  <= 1'b0;
      end else begin
         low_power_rc_osc_en_reg <= wdt_en;
         window_reg  <= !cfg_window_mode_disable && cfg_en;
      end
   end

   // read data, valid the cycle after the read strobe
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         rdata_reg <= '0;
      end else if (reg_rd) begin
         case (reg_addr)
            OFS_CONFIG:     rdata_reg <= DATA_W'(cfg_reg | ~CFG_IMPL_MASK);
            OFS_RESET_CTRL: rdata_reg <= DATA_W'({soft_en_reg, timeout_flag_reg,
                                                  sleep_bit_reg, idle_bit_reg, 2'b00});
            OFS_IRQ_STATUS: rdata_reg <= DATA_W'(irq_stat_reg);
            OFS_IRQ_ENABLE: rdata_reg <= DATA_W'(irq_en_reg);
            OFS_COUNT:      rdata_reg <= {post_cnt_reg, 1'b0, pre_cnt_reg, 6'h00, wdt_en, cfg_prog_reg};
            default:        rdata_reg <= '0;
         endcase
      end else begin
         rdata_reg <= '0;
      end
   end

   assign reg_rdata           = rdata_reg;
   assign low_power_rc_osc_en = low_power_rc_osc_en_reg;
   assign wdt_reset_out       = wdt_reset_reg;
   assign wake_out            = wake_reg;
   assign sleep_active        = slp_reg;
   assign idle_active         = idl_reg;
   assign window_mode_active  = window_reg;
   assign irq                 = irq_reg;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   osc_enable_a: assert property (wdt_en |=> low_power_rc_osc_en)
      else $error("oscillator not enabled while watchdog runs");
   presc_ratio_a: assert property (low_power_rc_osc_tick && cfg_presel && pre_cnt_reg == 7'h1F && !cnt_clear
                                   |=> pre_cnt_reg == 7'h20)
      else $error("long prescaler wrapped at 32");
   presc_period_a: assert property (pre_tick |-> 32'(pre_cnt_reg) + 1 ==
                                    (cfg_presel ? PRE_TICKS_LONG : PRE_TICKS_SHORT))
      else $error("prescaler period wrong");
   post_ratio_a: assert property (timeout_hit |-> post_cnt_reg == post_last(cfg_post))
      else $error("postscaler terminal wrong");
   reset_clear_a: assert property (dev_reset_in |=> pre_cnt_reg == '0 && post_cnt_reg == '0)
      else $error("device reset left counters");
   switch_clear_a: assert property (clk_switch_done |=> pre_cnt_reg == '0 && post_cnt_reg == '0)
      else $error("clock switch left counters");
   lp_entry_a: assert property (lp_entry && !dev_reset_in |=> in_lp && post_cnt_reg == '0)
      else $error("power-save entry wrong");
   lp_wake_a: assert property (timeout_hit && in_lp |=> !in_lp && wake_out && timeout_flag_reg)
      else $error("timeout did not wake");
   flag_sticky_a: assert property (timeout_flag_reg && !rc_write |=> timeout_flag_reg)
      else $error("timeout flag cleared by hardware");
   hw_enable_a: assert property (cfg_en |=> low_power_rc_osc_en)
      else $error("config enable ignored");
   sw_enable_a: assert property (!cfg_en && !soft_en_reg
                                 |=> pre_cnt_reg == '0 && post_cnt_reg == '0 && !low_power_rc_osc_en)
      else $error("software enable ignored");
   sw_reset_a: assert property (dev_any_reset |=> !soft_en_reg)
      else $error("software enable survived reset");
   run_reset_a: assert property (timeout_hit && !in_lp |=> wdt_reset_out ##1 !soft_en_reg)
      else $error("run timeout did not reset");

   run_timeout_c: cover property (timeout_hit && !in_lp);
   sleep_wake_c:  cover property (sleep_active && timeout_hit);
   clear_instr_c: cover property (clear_watchdog_instr && !in_lp && post_cnt_reg != '0);

endmodule

// ---- dv/wdtc_watchdog_tb.sv ----
// bench for the watchdog block: timeout periods, clear events, power save, config word, irq
// assumes the design is built with a 4-cycle oscillator tick and driven on core_clk only
`timescale 1ns/10ps
module wdtc_watchdog_tb
   import wdtc_pkg::*;
;
   localparam int DIV = 4;
   logic              core_clk;
   logic              rst_b;
   logic              reg_wr;
   logic              reg_rd;
   logic              psv_idle;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata;
   logic [DATA_W-1:0] reg_rdata;
   logic [4:0]        ev;
   logic              osc_en;
   logic              rst_out;
   logic              wake_out;
   logic              slp;
   logic              idl;
   logic              win;
   logic              irq;
   int                err_count = 0;
   int                n_compared = 0;
   int                n_rst = 0;
   int                n;
   int                m;
   int                seed;
   // en, window disable, prescale, postscale settings
   logic [31:0]       cfgs [5] = '{32'h00FF_FFE0, 32'h00FF_FFF0, 32'h00FF_FFE1, 32'h00FF_FFA3, 32'h00FF_FFF2};

   // ev: 0 device reset, 1 clock switch, 2 power save, 3 clear instruction, 4 wake
   wdtc_watchdog #(.LOW_POWER_RC_OSC_DIV_P(DIV)) u_wdtc_watchdog (
      .clk_core_placeholder_unused_never (1'b0),
      .core_clk             (core_clk),
      .rst_b                (rst_b),
      .reg_addr             (reg_addr),
      .reg_wdata            (reg_wdata),
      .reg_wr               (reg_wr),
      .reg_rd               (reg_rd),
      .reg_rdata            (reg_rdata),
      .dev_reset_in         (ev[0]),
      .clk_switch_done      (ev[1]),
      .power_save_instr     (ev[2]),
      .power_save_idle      (psv_idle),
      .clear_watchdog_instr (ev[3]),
      .wake_in              (ev[4]),
      .low_power_rc_osc_en  (osc_en),
      .wdt_reset_out        (rst_out),
      .wake_out             (wake_out),
      .sleep_active         (slp),
      .idle_active          (idl),
      .window_mode_active   (win),
      .irq                  (irq)
   );

   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   always @(posedge core_clk) begin
      if (rst_out === 1'b1) n_rst <= n_rst + 1;
   end

   function automatic int per(input logic [31:0] c);
      return ((c[4] ? 128 : 32) << c[3:0]) * DIV;
   endfunction

   task automatic results();
      if (err_count == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string w);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t %s got %h exp %h", $time, w, got, exp);
      end
   endtask

   task automatic chk_time(input int got, input int exp);
      n_compared++;
      if (got < exp - 4 || got > exp + 4) begin
         err_count++;
         $display("BAD %0t period %0d exp %0d", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rdr(input logic [7:0] a, input logic [31:0] msk, input logic [31:0] e, input string w);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      chk_val(reg_rdata & msk, e, w);
   endtask

   task automatic pulse(input int i);
      @(posedge core_clk);
      ev[i] <= 1'b1;
      @(posedge core_clk);
      ev <= '0;
   endtask

   // counts cycles up to a reset (wk 0) or wake (wk 1) pulse
   task automatic wait_pulse(input bit wk, input int lim, output int cyc);
      cyc = 0;
      do begin
         @(posedge core_clk);
         #1;
         cyc++;
      end while (((wk ? wake_out : rst_out) !== 1'b1) && cyc <= lim);
      if (cyc > lim) begin
         err_count++;
         $display("BAD %0t pulse missing", $time);
         results();
      end
   endtask

   task automatic boot(input logic [31:0] cfg);
      rst_b <= 1'b0;
      repeat (20) @(posedge core_clk);
      rst_b <= 1'b1;
      rdr(OFS_CONFIG, 32'h00FF_FFFF, 32'h00FF_FFFF, "unprogrammed");
      wr(OFS_CONFIG, cfg);
      wr(OFS_CONFIG, 32'h0000_0000);
      rdr(OFS_CONFIG, 32'h00FF_FFFF, cfg, "config");
   endtask

   initial begin
      #500_000;
      err_count++;
      $display("BAD %0t run too long", $time);
      results();
   end

   initial begin
      seed = 32'hc21b;
      rst_b = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = '0;
      reg_wdata = '0;
      ev = '0;
      psv_idle = 1'b0;
      foreach (cfgs[k]) begin
         boot(cfgs[k]);
         chk_val(osc_en, 1, "osc");
         chk_val(win, cfgs[k][7] & ~cfgs[k][6], "window");
         wr(OFS_IRQ_ENABLE, k == 0);
         pulse(3);
         wait_pulse(0, 10000, n);
         chk_time(n, per(cfgs[k]));
         rdr(OFS_RESET_CTRL, 32'h0000_003C, 32'h0000_0010, "flag");
         @(posedge core_clk);
         #1;
         chk_val(irq, k == 0, "irq mask");
      end
      // random spacing of device reset, clock switch and clear instruction keeps the timeout away
      boot(cfgs[0]);
      m = n_rst;
      for (int i = 0; i < 30; i++) begin
         repeat (40 + $unsigned($random(seed)) % 60) @(posedge core_clk);
         pulse(i % 3 == 2 ? 3 : i % 3);
      end
      chk_val(n_rst - m, 0, "kick");
      wr(OFS_IRQ_ENABLE, 1);
      rdr(OFS_IRQ_ENABLE, 32'h0000_0003, 32'h0000_0001, "irq enable");
      wait_pulse(0, 1000, n);
      rdr(OFS_IRQ_STATUS, 32'h0000_0003, 32'h0000_0001, "status");
      chk_val(irq, 1, "irq");
      wr(OFS_IRQ_CLEAR, 1);
      @(posedge core_clk);
      #1;
      chk_val(irq, 0, "irq clear");
      rdr(OFS_RESET_CTRL, 32'h0000_0010, 32'h0000_0010, "sticky");
      wr(OFS_RESET_CTRL, 0);
      rdr(OFS_RESET_CTRL, 32'h0000_0010, 0, "flag clear");
      rdr(8'h20, 32'hFFFF_FFFF, 0, "unmapped");
      for (int i = 0; i < 4; i++) begin
         m = n_rst;
         psv_idle <= i[0];
         pulse(3);
         repeat (20 + $unsigned($random(seed)) % 80) @(posedge core_clk);
         pulse(2);
         #1;
         chk_val({slp, idl}, i[0] ? 2'b01 : 2'b10, "power save");
         if (i > 1) begin
            repeat (50) @(posedge core_clk);
            pulse(4);
            #1;
            chk_val(wake_out, 1, "wake in");
            wait_pulse(0, 1000, n);
            chk_time(n, per(cfgs[0]));
         end else begin
            wait_pulse(1, 1000, n);
            chk_time(n, per(cfgs[0]));
            chk_val(n_rst - m, 0, "reset in sleep");
            rdr(OFS_IRQ_STATUS, 32'h0000_0002, 32'h0000_0002, "wake status");
         end
         chk_val({slp, idl}, 0, "awake");
         rdr(OFS_RESET_CTRL, 32'h0000_000C, i[0] ? 4 : 8, "power bits");
         wr(OFS_RESET_CTRL, 0);
      end
      // hardware enable off: only the software bit runs the timer
      boot(32'h00FF_FF60);
      m = n_rst;
      repeat (300) @(posedge core_clk);
      chk_val(osc_en, 0, "off");
      chk_val(n_rst - m, 0, "off reset");
      rdr(OFS_COUNT, 32'hFFFF_FFFF, 32'h0000_0001, "count idle");
      wr(OFS_RESET_CTRL, 32'h0000_0020);
      pulse(3);
      chk_val(osc_en, 1, "soft on");
      wait_pulse(0, 1000, n);
      chk_time(n, per(32'h00FF_FF60));
      rdr(OFS_RESET_CTRL, 32'h0000_0030, 32'h0000_0010, "soft cleared");
      chk_val(osc_en, 0, "osc off");
      wr(OFS_RESET_CTRL, 32'h0000_0020);
      pulse(0);
      rdr(OFS_RESET_CTRL, 32'h0000_0020, 0, "dev reset");
      results();
   end
endmodule
